// ### design/out_drv_ctrl.sv
// Purpose: Control and protection of three half bridges and three high-side switches
// Assumes: AHB-Lite word accesses; diagnostic and PWM inputs synchronous to ref_clk
// Notes: Status registers are write-one-to-clear; a set wins over a register clear but not over standby
`timescale 1ns/1ns
`include "out_drv_consts.svh"

module out_drv_ctrl #(
    parameter logic [`CNT_W-1:0] OL_FILTER_CYC = `CNT_W'(`FILT_LONG_CYC),
    parameter logic [`CNT_W-1:0] OC_RETRY_CYC = `CNT_W'(`OC_RETRY_CYC),
    parameter logic [`XC_W-1:0] XC_DELAY_CYC = `XC_W'(`XC_DELAY_CYC)
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [5:0] oc_raw,
    input wire logic [5:0] low_load_raw,
    input wire logic ov_raw,
    input wire logic uv_raw,
    input wire logic tw_raw,
    input wire logic tsd_raw,
    input wire logic gate_input_a,
    input wire logic monitor_or_gate_b_pin,
    output logic [2:0] high_switch,
    output logic [2:0] low_switch,
    output logic [2:0] fast_turn_off,
    output logic highside_output_heavy,
    output logic highside_output_second,
    output logic highside_output_third,
    output logic charge_pump_en,
    output logic load_current_image_en,
    output logic [1:0] load_current_image_sel
);
    import out_drv_pkg::*;

    localparam logic [`CNT_W-1:0] SHORT_CYC = `CNT_W'(`FILT_SHORT_CYC);

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic noerr;
    logic [31:0] stat0_w;
    logic [31:0] stat1_w;
    logic [31:0] ctrl0_w;
    logic [31:0] ctrl1_w;
    logic [31:0] state_w;
    logic [5:0] out_on;

    filt_if #(.N(`FCH_N)) fb ();

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // Diagnostic filters
    // ----------------------------------------
    assign out_on = {s_q.hso, s_q.hs | s_q.ls};
    assign fb.raw = {tsd_raw, tw_raw, uv_raw, ov_raw, low_load_raw, oc_raw};
    assign fb.en = {{4{s_q.active}}, out_on, {6{s_q.active}}};

    diag_filter_bank #(
        .N(`FCH_N),
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(OL_FILTER_CYC),
        .LONG_MASK(`FCH_N'(`FCH_LONG_MASK))
    ) u_filt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .fb(fb)
    );

    // ----------------------------------------
    // Register images
    // ----------------------------------------
    assign noerr = ~(|s_q.oc | |s_q.ol | s_q.ov | s_q.uv | s_q.tw | s_q.tsd);
    assign stat0_w = {19'h0, s_q.ol, s_q.oc, noerr};
    assign stat1_w = {27'h0, s_q.tsd, s_q.tw, s_q.uv, s_q.ov, noerr};
    assign ctrl0_w = {8'h0, s_q.active, 2'h0, s_q.sup_dis, s_q.msel, 2'h0, s_q.oc_rec,
                      s_q.drv, 1'b0};
    assign ctrl1_w = {25'h0, s_q.pwm_en, 1'b0};
    assign state_w = {20'h0, s_q.sup_off, s_q.mon_valid, s_q.active, s_q.hso, s_q.ls, s_q.hs};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic req;
        logic clr_all;
        logic [31:0] w1c0;
        logic [31:0] w1c1;
        logic en_all;
        logic [5:0] allow;
        logic [5:0] gate;
        logic t_hs;
        logic t_ls;
        logic sel_on;
        req = 1'b0;
        clr_all = 1'b0;
        w1c0 = 32'h0;
        w1c1 = 32'h0;
        en_all = 1'b0;
        allow = 6'h0;
        gate = 6'h0;
        t_hs = 1'b0;
        t_ls = 1'b0;
        sel_on = 1'b0;
        s_d = s_q;

        // Bus slave: zero wait states, always OKAY
        req = hsel && hready && htrans[1];
        s_d.ph_wr = req && hwrite;
        s_d.ph_addr = haddr[7:0];
        s_d.rdy = 1'b1;
        s_d.resp = 1'b0;
        s_d.rdata = 32'h0;
        if (req && !hwrite) begin
            if (reg_hit(haddr[7:0], `REG_CTRL0)) s_d.rdata = ctrl0_w;
            if (reg_hit(haddr[7:0], `REG_CTRL1)) s_d.rdata = ctrl1_w;
            if (reg_hit(haddr[7:0], `REG_STAT0)) s_d.rdata = stat0_w;
            if (reg_hit(haddr[7:0], `REG_STAT1)) s_d.rdata = stat1_w;
            if (reg_hit(haddr[7:0], `REG_STATE)) s_d.rdata = state_w;
        end
        if (s_q.ph_wr) begin
            if (reg_hit(s_q.ph_addr, `REG_CTRL0)) begin
                s_d.active = hwdata[`C0_ACTIVE];
                s_d.drv = hwdata[`C0_DRV +: 9];
                s_d.oc_rec = hwdata[`C0_OCREC +: 6];
                s_d.msel = hwdata[`C0_MSEL +: 2];
                s_d.sup_dis = hwdata[`C0_SUPDIS];
                clr_all = hwdata[`C0_CLR];
            end
            if (reg_hit(s_q.ph_addr, `REG_CTRL1)) begin
                s_d.pwm_en = hwdata[`C1_PWMEN +: 6];
                clr_all = hwdata[`C1_CLR];
            end
            if (reg_hit(s_q.ph_addr, `REG_STAT0)) w1c0 = hwdata;
            if (reg_hit(s_q.ph_addr, `REG_STAT1)) w1c1 = hwdata;
        end

        // Flags: a new hit wins over a register clear, not over standby
        for (int k = 0; k < 6; k++) begin
            s_d.oc[k] = (s_q.oc[k] && !(clr_all || w1c0[`S0_OC + k])) || fb.hit[k];
            s_d.ol[k] = (s_q.ol[k] && !(clr_all || w1c0[`S0_OC + 6 + k]))
                        || fb.hit[`FCH_OL + k];
        end
        s_d.ov = (s_q.ov && !(clr_all || w1c1[`S1_OV])) || fb.hit[`FCH_OV];
        s_d.uv = (s_q.uv && !(clr_all || w1c1[`S1_UV])) || fb.hit[`FCH_UV];
        s_d.tw = (s_q.tw && !((clr_all || w1c1[`S1_TW]) && !tw_raw))
                 || fb.hit[`FCH_TW];
        s_d.tsd = (s_q.tsd && !((clr_all || w1c1[`S1_TSD]) && !tsd_raw))
                  || fb.hit[`FCH_TSD];

        // Per output overcurrent shutdown and retry
        for (int k = 0; k < 6; k++) begin
            if (fb.hit[k]) begin
                s_d.oc_off[k] = 1'b1;
                s_d.retry[k] = OC_RETRY_CYC;
            end else if (s_q.oc_rec[k]) begin
                if (s_q.retry[k] != '0) begin
                    s_d.retry[k] = s_q.retry[k] - 1'b1;
                end else begin
                    s_d.oc_off[k] = 1'b0;
                end
            end else begin
                s_d.oc_off[k] = s_q.oc_off[k] && s_d.oc[k];
            end
        end

        // Supply fault shutdown and recovery
        if (fb.hit[`FCH_OV] || fb.hit[`FCH_UV]) begin
            s_d.sup_off = 1'b1;
            s_d.sup_cnt = SHORT_CYC;
        end else if (s_q.sup_off) begin
            if (s_q.sup_dis) begin
                s_d.sup_off = s_d.ov || s_d.uv;
            end else if (ov_raw || uv_raw) begin
                s_d.sup_cnt = SHORT_CYC;
            end else if (s_q.sup_cnt != '0) begin
                s_d.sup_cnt = s_q.sup_cnt - 1'b1;
            end else begin
                s_d.sup_off = 1'b0;
            end
        end

        // Standby drops every latched setting and flag
        if (!s_d.active) begin
            s_d.drv = '0;
            s_d.oc_rec = '0;
            s_d.msel = '0;
            s_d.sup_dis = 1'b0;
            s_d.pwm_en = '0;
            s_d.oc = '0;
            s_d.ol = '0;
            s_d.ov = 1'b0;
            s_d.uv = 1'b0;
            s_d.tw = 1'b0;
            s_d.tsd = 1'b0;
            s_d.oc_off = '0;
            s_d.retry = '0;
            s_d.sup_off = 1'b0;
            s_d.sup_cnt = '0;
        end
        s_d.cp_en = s_d.active;

        // Output permission; open load and warning are not consulted
        en_all = s_d.active && !s_d.tsd && !s_d.sup_off;
        for (int k = 0; k < 6; k++) begin
            allow[k] = en_all && !s_d.oc_off[k];
            gate[k] = !s_d.pwm_en[k]
                      || ((k == 4) ? monitor_or_gate_b_pin : gate_input_a);
        end

        // Half bridges with dead time
        for (int b = 0; b < 3; b++) begin
            t_hs = allow[b] && gate[b] && s_d.drv[2*b] && !s_d.drv[2*b+1];
            t_ls = allow[b] && gate[b] && s_d.drv[2*b+1] && !s_d.drv[2*b];
            s_d.fast[b] = 1'b0;
            unique case (s_q.xc[b])
                XS_IDLE: begin
                    if (t_hs) begin
                        s_d.xc[b] = XS_HIGH;
                        s_d.hs[b] = 1'b1;
                    end else if (t_ls) begin
                        s_d.xc[b] = XS_LOW;
                        s_d.ls[b] = 1'b1;
                    end
                end
                XS_HIGH: begin
                    if (!t_hs) begin
                        s_d.hs[b] = 1'b0;
                        s_d.last_hs[b] = 1'b1;
                        s_d.xc_cnt[b] = XC_DELAY_CYC;
                        s_d.xc[b] = XS_DEAD;
                    end
                end
                XS_LOW: begin
                    if (!t_ls) begin
                        s_d.ls[b] = 1'b0;
                        s_d.last_hs[b] = 1'b0;
                        s_d.xc_cnt[b] = XC_DELAY_CYC;
                        s_d.xc[b] = XS_DEAD;
                    end
                end
                XS_DEAD: begin
                    if (s_q.last_hs[b] && t_hs) begin
                        s_d.xc[b] = XS_HIGH;
                        s_d.hs[b] = 1'b1;
                    end else if (!s_q.last_hs[b] && t_ls) begin
                        s_d.xc[b] = XS_LOW;
                        s_d.ls[b] = 1'b1;
                    end else if (s_q.xc_cnt[b] != '0) begin
                        s_d.xc_cnt[b] = s_q.xc_cnt[b] - 1'b1;
                    end else if (t_hs || t_ls) begin
                        s_d.xc[b] = t_hs ? XS_HIGH : XS_LOW;
                        s_d.hs[b] = t_hs;
                        s_d.ls[b] = t_ls;
                        s_d.fast[b] = 1'b1;
                    end else begin
                        s_d.xc[b] = XS_IDLE;
                    end
                end
                default: begin
                    s_d.xc[b] = XS_IDLE;
                    s_d.hs[b] = 1'b0;
                    s_d.ls[b] = 1'b0;
                end
            endcase
        end

        // High-side switches
        for (int j = 0; j < 3; j++) begin
            s_d.hso[j] = allow[3+j] && gate[3+j] && s_d.drv[6+j];
        end

        // Current monitor selection and blanking
        unique case (s_d.msel)
            2'h0: sel_on = s_d.hs[0];
            2'h1: sel_on = s_d.hso[0];
            2'h2: sel_on = s_d.hso[1];
            2'h3: sel_on = s_d.hso[2];
        endcase
        s_d.blank_sel = s_d.msel;
        if (!sel_on || (s_d.msel != s_q.blank_sel)) begin
            s_d.blank_cnt = '0;
            s_d.mon_valid = 1'b0;
        end else if (s_q.blank_cnt != SHORT_CYC) begin
            s_d.blank_cnt = s_q.blank_cnt + 1'b1;
            s_d.mon_valid = 1'b0;
        end else begin
            s_d.mon_valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.xc <= {3{XS_IDLE}};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hreadyout = s_q.rdy;
    assign hresp = s_q.resp;
    assign hrdata = s_q.rdata;
    assign high_switch = s_q.hs;
    assign low_switch = s_q.ls;
    assign fast_turn_off = s_q.fast;
    assign highside_output_heavy = s_q.hso[0];
    assign highside_output_second = s_q.hso[1];
    assign highside_output_third = s_q.hso[2];
    assign charge_pump_en = s_q.cp_en;
    assign load_current_image_en = s_q.mon_valid;
    assign load_current_image_sel = s_q.msel;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_all_off;
        (s_q.hs == 3'h0) && (s_q.ls == 3'h0) && (s_q.hso == 3'h0);
    endsequence

    property p_standby_off;
        !s_q.active |-> s_all_off;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("driver on in standby");

    property p_cp_follows;
        $rose(s_q.active) |-> s_q.cp_en ##1 (s_q.cp_en || !s_q.active);
    endproperty
    a_cp_follows: assert property (p_cp_follows) else $error("charge pump not on");

    property p_oc_off;
        $rose(s_q.oc[3]) |-> !s_q.hso[0] && s_q.oc_off[3];
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("overcurrent output stays on");

    property p_tsd_off;
        s_q.tsd |-> s_all_off;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("output on in shutdown");

    property p_sup_off;
        s_q.sup_off |-> s_all_off;
    endproperty
    a_sup_off: assert property (p_sup_off) else $error("output on in supply fault");

    property p_tw_hold;
        (s_q.tw && tw_raw) |=> s_q.tw || !s_q.active;
    endproperty
    a_tw_hold: assert property (p_tw_hold) else $error("warning cleared while hot");

    property p_blank;
        $rose(s_q.mon_valid) |-> $past(s_q.blank_cnt) == SHORT_CYC;
    endproperty
    a_blank: assert property (p_blank) else $error("monitor unblanked early");

    sequence s_opposite_on;
        $rose(s_q.ls[0]) && s_q.last_hs[0] && ($past(s_q.xc[0]) == XS_DEAD);
    endsequence

    property p_deadtime;
        s_opposite_on |-> s_q.fast[0] && $past(s_q.xc_cnt[0]) == '0;
    endproperty
    a_deadtime: assert property (p_deadtime) else $error("opposite switch early");

    property p_no_shoot;
        !(s_q.hs[1] && s_q.ls[1]);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both switches on");

    property p_noerr;
        (s_q.tsd || s_q.ol[2]) |-> !noerr;
    endproperty
    a_noerr: assert property (p_noerr) else $error("no-error bit wrong");
endmodule

// ### design/out_drv_consts.svh
// Purpose: Constants for the output driver protection controller
// Assumes: 100 MHz ref_clk
// Notes: Register offsets are byte addresses on the AHB-Lite slave
`ifndef OUT_DRV_CONSTS_SVH
`define OUT_DRV_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 100
`define FILT_SHORT_US 32
`define FILT_LONG_MS 1
`define OC_RETRY_US 400
`define FILT_SHORT_CYC (`FILT_SHORT_US * `CLK_MHZ)
`define FILT_LONG_CYC (`FILT_LONG_MS * 1000 * `CLK_MHZ)
`define OC_RETRY_CYC (`OC_RETRY_US * `CLK_MHZ)
`define XC_DELAY_CYC 100
`define CNT_W 17
`define XC_W 8

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL0 8'h00
`define REG_CTRL1 8'h04
`define REG_STAT0 8'h08
`define REG_STAT1 8'h0C
`define REG_STATE 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define C0_DRV 1
`define C0_OCREC 10
`define C0_MSEL 18
`define C0_SUPDIS 20
`define C0_CLR 22
`define C0_ACTIVE 23
`define C1_PWMEN 1
`define C1_CLR 22
`define S1_OV 1
`define S1_UV 2
`define S1_TW 3
`define S1_TSD 4
`define S0_OC 1

// ----------------------------------------
// Filter channel map
// ----------------------------------------
`define FCH_N 16
`define FCH_OL 6
`define FCH_OV 12
`define FCH_UV 13
`define FCH_TW 14
`define FCH_TSD 15
`define FCH_LONG_MASK 16'h0FC0

`endif

// ### design/out_drv_pkg.sv
// Purpose: Types for the output driver protection controller
// Assumes: Constants header on the include path
// Notes: State of the top module is one packed struct
`include "out_drv_consts.svh"

package out_drv_pkg;

    // ----------------------------------------
    // Half bridge sequencing
    // ----------------------------------------
    typedef enum logic [3:0] {
        XS_IDLE = 4'b0001,
        XS_HIGH = 4'b0010,
        XS_LOW = 4'b0100,
        XS_DEAD = 4'b1000
    } xc_state_t;

    // ----------------------------------------
    // Controller state
    // ----------------------------------------
    typedef struct packed {
        logic active;
        logic [8:0] drv;
        logic [5:0] oc_rec;
        logic [1:0] msel;
        logic sup_dis;
        logic [5:0] pwm_en;
        logic [5:0] oc;
        logic [5:0] ol;
        logic ov;
        logic uv;
        logic tw;
        logic tsd;
        logic [5:0] oc_off;
        logic [5:0][`CNT_W-1:0] retry;
        logic sup_off;
        logic [`CNT_W-1:0] sup_cnt;
        xc_state_t [2:0] xc;
        logic [2:0][`XC_W-1:0] xc_cnt;
        logic [2:0] last_hs;
        logic [2:0] hs;
        logic [2:0] ls;
        logic [2:0] fast;
        logic [2:0] hso;
        logic [`CNT_W-1:0] blank_cnt;
        logic [1:0] blank_sel;
        logic mon_valid;
        logic cp_en;
        logic ph_wr;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        logic rdy;
        logic resp;
    } ctl_state_t;

endpackage

// ### design/filt_if.sv
// Purpose: Carrier between controller and diagnostic filter bank
// Assumes: Same clock on both sides
// Notes: Raw and enable in, persisted hit out
`timescale 1ns/1ns

interface filt_if #(parameter int N = 16);
    logic [N-1:0] raw;
    logic [N-1:0] en;
    logic [N-1:0] hit;
    modport owner (output raw, output en, input hit);
    modport bank (input raw, input en, output hit);
endinterface

// ### design/diag_filter_bank.sv
// Purpose: Persistence filters for the diagnostic conditions
// Assumes: Raw conditions synchronous to ref_clk
// Notes: Hit stays high while the condition and its enable keep holding
`timescale 1ns/1ns
`include "out_drv_consts.svh"

module diag_filter_bank #(
    parameter int N = `FCH_N,
    parameter logic [`CNT_W-1:0] SHORT_CYC = `CNT_W'(`FILT_SHORT_CYC),
    parameter logic [`CNT_W-1:0] LONG_CYC = `CNT_W'(`FILT_LONG_CYC),
    parameter logic [N-1:0] LONG_MASK = N'(`FCH_LONG_MASK)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    filt_if.bank fb
);
    typedef struct packed {
        logic [N-1:0][`CNT_W-1:0] cnt;
        logic [N-1:0] hit;
    } filt_state_t;

    filt_state_t f_q;
    filt_state_t f_d;
    logic [N-1:0][`CNT_W-1:0] lim;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_lim
            assign lim[g] = LONG_MASK[g] ? LONG_CYC : SHORT_CYC;
        end
    endgenerate

    // ----------------------------------------
    // Count unbroken presence
    // ----------------------------------------
    always_comb begin
        f_d = f_q;
        for (int i = 0; i < N; i++) begin
            if (fb.raw[i] && fb.en[i]) begin
                if (f_q.cnt[i] != lim[i]) begin
                    f_d.cnt[i] = f_q.cnt[i] + 1'b1;
                end
            end else begin
                f_d.cnt[i] = '0;
            end
            f_d.hit[i] = (f_d.cnt[i] == lim[i]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    assign fb.hit = f_q.hit;

    property p_filter_len;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(f_q.hit[0]) |-> ($past(f_q.cnt[0]) == lim[0] - 1'b1);
    endproperty
    a_filter_len: assert property (p_filter_len) else $error("filter hit early");

    property p_filter_drop;
        @(posedge ref_clk) disable iff (!rst_n)
        !fb.raw[1] |=> !f_q.hit[1];
    endproperty
    a_filter_drop: assert property (p_filter_drop) else $error("hit without condition");
endmodule

// ### verification/far_side_pwm.sv
// Purpose: External PWM sources feeding both gate pins
// Assumes: Levels commanded by the bench
// Notes: Pins change only just after a rising edge
`timescale 1ns/1ns

module far_side_pwm (
    input wire logic ref_clk,
    input wire logic lvl_a,
    input wire logic lvl_b,
    output logic gate_input_a,
    output logic monitor_or_gate_b_pin
);
    always_ff @(posedge ref_clk) begin
        gate_input_a <= lvl_a;
        monitor_or_gate_b_pin <= lvl_b;
    end
endmodule

// ### verification/test_output_driver_protection_ctrl.sv
// Purpose: Self-checking bench for out_drv_ctrl
// Assumes: Reduced open-load, retry and dead-time counts
// Notes: AHB-Lite single word transfers only
`timescale 1ns/1ns

module test_output_driver_protection_ctrl;
    logic ref_clk, resetn, hsel, hwrite, hreadyout, hresp, lvl_a, lvl_b, ga, gb, cp;
    logic hvy, sec, thd, ov_raw, uv_raw, tw_raw, tsd_raw, mv;
    logic [1:0] htrans;
    logic [2:0] hs, ls, ft;
    logic [5:0] oc_raw, ll_raw;
    logic [31:0] haddr, hwdata, hrdata, r;
    int bad_count, num_checks;

    out_drv_ctrl #(.OL_FILTER_CYC(17'd40), .OC_RETRY_CYC(17'd30), .XC_DELAY_CYC(8'd5)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .oc_raw(oc_raw),
        .low_load_raw(ll_raw), .ov_raw(ov_raw), .uv_raw(uv_raw), .tw_raw(tw_raw),
        .tsd_raw(tsd_raw), .gate_input_a(ga), .monitor_or_gate_b_pin(gb),
        .high_switch(hs), .low_switch(ls), .fast_turn_off(ft), .highside_output_heavy(hvy),
        .highside_output_second(sec), .highside_output_third(thd), .charge_pump_en(cp),
        .load_current_image_en(mv), .load_current_image_sel());
    far_side_pwm pwm (.ref_clk(ref_clk), .lvl_a(lvl_a), .lvl_b(lvl_b),
        .gate_input_a(ga), .monitor_or_gate_b_pin(gb));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(r & m, e);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rc(8'h10, 32'h00000FFF, 32'h00000000);
        rc(8'h08, 32'h00001FFF, 32'h00000001);
        chk(cp, 1'b0);
    endtask
    task t_oc;
        bus(1'b1, 8'h00, 32'h00800180);
        rc(8'h10, 32'h00000200, 32'h00000200);
        chk(cp, 1'b1);
        rc(8'h40, 32'hFFFFFFFF, 32'h00000000);
        oc_raw <= 6'h08;
        cyc(3190);
        chk(hvy, 1'b1);
        cyc(20);
        chk({hvy, sec}, 2'b01);
        rc(8'h08, 32'h00000011, 32'h00000010);
        oc_raw <= 6'h00;
        cyc(40);
        chk(hvy, 1'b0);
        bus(1'b1, 8'h08, 32'h00000010);
        cyc(2);
        chk(hvy, 1'b1);
    endtask
    task t_supply;
        ov_raw <= 1'b1;
        cyc(3210);
        chk({hvy, sec}, 2'b00);
        rc(8'h0C, 32'h00000003, 32'h00000002);
        ov_raw <= 1'b0;
        cyc(3100);
        chk(hvy, 1'b0);
        cyc(150);
        chk({hvy, sec}, 2'b11);
    endtask
    task t_pwm;
        bus(1'b1, 8'h04, 32'h00000030);
        lvl_a <= 1'b0;
        cyc(4);
        chk({hvy, sec}, 2'b01);
        lvl_a <= 1'b1;
        lvl_b <= 1'b0;
        cyc(4);
        chk({hvy, sec}, 2'b10);
    endtask
    task t_standby;
        bus(1'b1, 8'h00, 32'h00000000);
        cyc(2);
        chk({cp, hvy, sec, thd, hs, ls}, 10'h000);
        rc(8'h0C, 32'h0000001F, 32'h00000001);
    endtask
    task t_por;
        resetn <= 1'b0;
        cyc(1);
        chk({cp, hvy, sec}, 3'h0);
        resetn <= 1'b1;
        do cyc(1); while (hreadyout !== 1'b1);
        rc(8'h0C, 32'h0000001F, 32'h00000001);
        bus(1'b1, 8'h00, 32'h00800180);
    endtask
    task t_temp;
        tw_raw <= 1'b1;
        cyc(3210);
        chk({hvy, sec}, 2'b11);
        rc(8'h0C, 32'h00000008, 32'h00000008);
        bus(1'b1, 8'h0C, 32'h00000008);
        rc(8'h0C, 32'h00000008, 32'h00000008);
        tw_raw <= 1'b0;
        tsd_raw <= 1'b1;
        cyc(3210);
        chk({hvy, sec}, 2'b00);
        tsd_raw <= 1'b0;
        bus(1'b1, 8'h0C, 32'h00000018);
        rc(8'h0C, 32'h00000018, 32'h00000000);
        chk({hvy, sec}, 2'b11);
    endtask
    task t_sup_dis;
        bus(1'b1, 8'h00, 32'h00900180);
        uv_raw <= 1'b1;
        cyc(3210);
        uv_raw <= 1'b0;
        cyc(3300);
        chk({hvy, sec}, 2'b00);
        bus(1'b1, 8'h04, 32'h00400000);
        cyc(2);
        chk({hvy, sec}, 2'b11);
        rc(8'h0C, 32'h0000001F, 32'h00000001);
    endtask
    task t_bridge;
        bus(1'b1, 8'h00, 32'h00800002);
        cyc(3000);
        rc(8'h10, 32'h00000409, 32'h00000001);
        cyc(210);
        rc(8'h10, 32'h00000409, 32'h00000401);
        chk(mv, 1'b1);
        ll_raw <= 6'h03;
        cyc(50);
        rc(8'h08, 32'h00000180, 32'h00000080);
        ll_raw <= 6'h00;
        bus(1'b1, 8'h00, 32'h00800004);
        cyc(5);
        chk({ft, hs, ls}, 9'h000);
        cyc(2);
        chk({ft, hs, ls}, 9'h041);
    endtask

    task wrap_up;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #600000;
        bad_count++;
        wrap_up;
    end
    initial begin
        {resetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {oc_raw, ll_raw, ov_raw, uv_raw, tw_raw, tsd_raw} = '0;
        {lvl_a, lvl_b} = 2'b11;
        cyc(3);
        resetn <= 1'b1;
        do cyc(1); while (hreadyout !== 1'b1);
        t_reset;
        t_oc;
        t_supply;
        t_por;
        t_temp;
        t_sup_dis;
        t_pwm;
        t_bridge;
        t_standby;
        wrap_up;
    end
endmodule
